/* core/dimc_pkg.sv */
// constants for the display input mode-control block
package dimc_pkg;
  // register addresses
  localparam logic [7:0] ADDR_MODE_ONE  = 8'h0E;
  localparam logic [7:0] ADDR_POL_CLAMP = 8'h0F;
  localparam logic [7:0] ADDR_MODE_TWO  = 8'h10;
  // reset values
  localparam logic [7:0] RST_MODE_ONE   = 8'hF8;
  localparam logic [7:0] RST_POL_CLAMP  = 8'hD0;
  localparam logic [7:0] RST_MODE_TWO   = 8'h30;
  // mode_control_one fields
  localparam int DUAL_SPLIT_BIT    = 7;
  localparam int PARALLEL_BIT      = 6;
  localparam int PORT_PHASE_BIT    = 5;
  localparam int HS_OUT_POL_BIT    = 4;
  localparam int VS_OUT_PASS_BIT   = 3;
  // input_polarity_clamp_clock_control fields
  localparam int HS_IN_POL_BIT     = 7;
  localparam int HOLD_IN_POL_BIT   = 6;
  localparam int CLAMP_SRC_BIT     = 5;
  localparam int CLAMP_SENSE_BIT   = 4;
  localparam int PCLK_SRC_BIT      = 3;
  localparam int CLAMP_MID_LSB     = 0;
  // mode_control_two fields
  localparam int DCLK_FLIP_BIT     = 7;
  localparam int PIX_SEL_BIT       = 6;
  localparam int DRIVE_MSB         = 5;
  localparam int DRIVE_LSB         = 4;
  localparam int TRISTATE_BIT      = 3;
  // writable bit masks, others read zero
  localparam logic [7:0] MASK_MODE_ONE  = 8'hF8;
  localparam logic [7:0] MASK_POL_CLAMP = 8'hFF;
  localparam logic [7:0] MASK_MODE_TWO  = 8'hF8;
  // widths
  localparam int PIX_W = 24;
  localparam int CNT_W = 8;

  typedef enum logic [1:0] {
    DRV_LOW  = 2'b00,
    DRV_MED  = 2'b01,
    DRV_HIGH = 2'b10
  } dimc_drive_t;

  typedef enum logic [1:0] {
    CLP_IDLE = 2'b00,
    CLP_WAIT = 2'b01,
    CLP_ON   = 2'b10
  } dimc_clamp_state_t;
endpackage : dimc_pkg

/* core/dimc_mode_ctrl.sv */
// mode-control registers and output steering of the display receiver
`timescale 1ns/1ps
module dimc_mode_ctrl (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic [7:0]                reg_addr_i,
  input  wire logic [7:0]                reg_wdata_i,
  input  wire logic                      reg_wr_i,
  output logic      [7:0]                reg_rdata_o,
  input  wire logic                      digital_if_i,
  input  wire logic                      hsync_in_i,
  input  wire logic                      vsync_in_i,
  input  wire logic                      green_embedded_sync_i,
  input  wire logic                      pll_holdover_input_i,
  input  wire logic                      ext_clamp_pin_i,
  input  wire logic [7:0]                clamp_start_offset_i,
  input  wire logic [7:0]                clamp_length_i,
  input  wire logic                      pix_valid_i,
  input  wire logic [dimc_pkg::PIX_W-1:0] pix_data_i,
  output logic      [dimc_pkg::PIX_W-1:0] port_a_data_o,
  output logic                           port_a_oe_o,
  output logic      [dimc_pkg::PIX_W-1:0] port_b_data_o,
  output logic                           port_b_oe_o,
  output logic      [1:0]                data_clk_o,
  output logic                           data_clk_oe_o,
  output logic                           hsync_o,
  output logic                           green_embedded_sync_o,
  output logic                           vsync_o,
  output logic                           hsync_lead_o,
  output logic                           pll_holdover_o,
  output logic                           pll_ref_edge_o,
  output logic                           pixel_clock_source_sel_o,
  output logic      [2:0]                clamp_active_o,
  output logic      [2:0]                clamp_midscale_o,
  output dimc_pkg::dimc_drive_t          drive_strength_o
);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0] mode_control_one;
  logic [7:0] input_polarity_clamp_clock_control;
  logic [7:0] mode_control_two;
  logic [7:0] next_mode_control_one;
  logic [7:0] next_input_polarity_clamp_clock_control;
  logic [7:0] next_mode_control_two;
  logic [7:0] next_reg_rdata;

  always_comb begin
    next_mode_control_one = mode_control_one;
    next_input_polarity_clamp_clock_control = input_polarity_clamp_clock_control;
    next_mode_control_two = mode_control_two;
    if (reg_wr_i) begin
      case (reg_addr_i)
        dimc_pkg::ADDR_MODE_ONE: begin
          next_mode_control_one = reg_wdata_i & dimc_pkg::MASK_MODE_ONE;
        end
        dimc_pkg::ADDR_POL_CLAMP: begin
          next_input_polarity_clamp_clock_control = reg_wdata_i & dimc_pkg::MASK_POL_CLAMP;
        end
        dimc_pkg::ADDR_MODE_TWO: begin
          next_mode_control_two = reg_wdata_i & dimc_pkg::MASK_MODE_TWO;
        end
        default: begin
          next_mode_control_one = mode_control_one;
        end
      endcase
    end
    case (reg_addr_i)
      dimc_pkg::ADDR_MODE_ONE:  next_reg_rdata = mode_control_one;
      dimc_pkg::ADDR_POL_CLAMP: next_reg_rdata = input_polarity_clamp_clock_control;
      dimc_pkg::ADDR_MODE_TWO:  next_reg_rdata = mode_control_two;
      default:                  next_reg_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_control_one <= dimc_pkg::RST_MODE_ONE;
      input_polarity_clamp_clock_control <= dimc_pkg::RST_POL_CLAMP;
      mode_control_two <= dimc_pkg::RST_MODE_TWO;
      reg_rdata_o <= 8'h00;
    end else begin
      mode_control_one <= next_mode_control_one;
      input_polarity_clamp_clock_control <= next_input_polarity_clamp_clock_control;
      mode_control_two <= next_mode_control_two;
      reg_rdata_o <= next_reg_rdata;
    end
  end

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  logic dual_port_split;
  logic port_phase_sel;
  logic hs_out_pol;
  logic vs_out_pass;
  logic hsync_in_polarity;
  logic holdover_in_polarity;
  logic clamp_source_sel;
  logic ext_clamp_sense;
  logic out_dataclk_flip;
  logic pix_sel;
  logic outputs_tristate;
  logic dual_mode;

  assign dual_port_split      = mode_control_one[dimc_pkg::DUAL_SPLIT_BIT];
  assign port_phase_sel       = mode_control_one[dimc_pkg::PORT_PHASE_BIT];
  assign hs_out_pol           = mode_control_one[dimc_pkg::HS_OUT_POL_BIT];
  assign vs_out_pass          = mode_control_one[dimc_pkg::VS_OUT_PASS_BIT];
  assign hsync_in_polarity    = input_polarity_clamp_clock_control[dimc_pkg::HS_IN_POL_BIT];
  assign holdover_in_polarity = input_polarity_clamp_clock_control[dimc_pkg::HOLD_IN_POL_BIT];
  assign clamp_source_sel     = input_polarity_clamp_clock_control[dimc_pkg::CLAMP_SRC_BIT];
  assign ext_clamp_sense      = input_polarity_clamp_clock_control[dimc_pkg::CLAMP_SENSE_BIT];
  assign out_dataclk_flip     = mode_control_two[dimc_pkg::DCLK_FLIP_BIT];
  assign pix_sel              = mode_control_two[dimc_pkg::PIX_SEL_BIT];
  assign outputs_tristate     = mode_control_two[dimc_pkg::TRISTATE_BIT];

  // digital pixel select acts like the analog split
  assign dual_mode = digital_if_i ? pix_sel : dual_port_split;

  // ----------------------------------------
  // sync, holdover and clamp source
  // ----------------------------------------
  logic hsync_q;
  logic hs_lead;
  logic holdover_act;
  logic ext_clamp_act;

  assign hs_lead = hsync_in_polarity ? (hsync_in_i & ~hsync_q) : (~hsync_in_i & hsync_q);
  assign holdover_act = (pll_holdover_input_i == holdover_in_polarity);
  // sense 0 clamps on high pin
  assign ext_clamp_act = ext_clamp_pin_i ^ ext_clamp_sense;

  // ----------------------------------------
  // internal clamp timer
  // ----------------------------------------
  dimc_pkg::dimc_clamp_state_t clp_state;
  dimc_pkg::dimc_clamp_state_t next_clp_state;
  logic [dimc_pkg::CNT_W-1:0]  clp_cnt;
  logic [dimc_pkg::CNT_W-1:0]  next_clp_cnt;

  // count samples from hsync leading edge
  always_comb begin
    next_clp_state = clp_state;
    next_clp_cnt = clp_cnt;
    if (hs_lead) begin
      next_clp_state = dimc_pkg::CLP_WAIT;
      next_clp_cnt = clamp_start_offset_i;
    end else if (pix_valid_i) begin
      case (clp_state)
        dimc_pkg::CLP_WAIT: begin
          if (clp_cnt <= 8'h01) begin
            next_clp_state = dimc_pkg::CLP_ON;
            next_clp_cnt = clamp_length_i;
          end else begin
            next_clp_cnt = clp_cnt - 8'h01;
          end
        end
        dimc_pkg::CLP_ON: begin
          if (clp_cnt <= 8'h01) begin
            next_clp_state = dimc_pkg::CLP_IDLE;
            next_clp_cnt = 8'h00;
          end else begin
            next_clp_cnt = clp_cnt - 8'h01;
          end
        end
        default: begin
          next_clp_state = dimc_pkg::CLP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clp_state <= dimc_pkg::CLP_IDLE;
      clp_cnt <= 8'h00;
      hsync_q <= 1'b0;
    end else begin
      clp_state <= next_clp_state;
      clp_cnt <= next_clp_cnt;
      hsync_q <= hsync_in_i;
    end
  end

  // ----------------------------------------
  // pixel steering and output registers
  // ----------------------------------------
  logic                       sample_odd;
  logic                       next_sample_odd;
  logic                       cur_odd;
  logic [dimc_pkg::PIX_W-1:0] next_port_a;
  logic [dimc_pkg::PIX_W-1:0] next_port_b;
  logic                       dclk_q;
  logic                       next_dclk_q;
  logic                       dclk_flip;

  always_comb begin
    cur_odd = hs_lead ? 1'b1 : sample_odd;
    next_sample_odd = cur_odd;
    next_port_a = port_a_data_o;
    next_port_b = port_b_data_o;
    next_dclk_q = pix_valid_i;
    if (pix_valid_i) begin
      next_sample_odd = ~cur_odd;
      if (!dual_mode) begin
        next_port_a = pix_data_i;
      end else if (cur_odd == port_phase_sel) begin
        // odd samples to A when phase 1
        next_port_a = pix_data_i;
      end else begin
        // phase 0 sends first sample to B
        next_port_b = pix_data_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sample_odd <= 1'b1;
      port_a_data_o <= 24'h000000;
      port_b_data_o <= 24'h000000;
      dclk_q <= 1'b0;
    end else begin
      sample_odd <= next_sample_odd;
      port_a_data_o <= next_port_a;
      port_b_data_o <= next_port_b;
      dclk_q <= next_dclk_q;
    end
  end

  assign dclk_flip = digital_if_i & out_dataclk_flip;
  assign data_clk_o = {2{dclk_q ^ dclk_flip}};

  assign port_a_oe_o = ~outputs_tristate;
  assign data_clk_oe_o = ~outputs_tristate;
  // port B floats in single port mode
  assign port_b_oe_o = ~outputs_tristate & dual_mode;

  // ----------------------------------------
  // sync outputs and analog controls
  // ----------------------------------------
  // normalise then apply output polarity
  assign hsync_o = (hsync_in_i ~^ hsync_in_polarity) ^ hs_out_pol;
  assign green_embedded_sync_o = green_embedded_sync_i ^ hs_out_pol;
  // vsync invert when bit is 0
  assign vsync_o = vsync_in_i ^ ~vs_out_pass;

  assign hsync_lead_o = hs_lead;
  assign pll_holdover_o = holdover_act;
  assign pll_ref_edge_o = hs_lead & ~holdover_act & ~pixel_clock_source_sel_o;
  assign pixel_clock_source_sel_o = input_polarity_clamp_clock_control[dimc_pkg::PCLK_SRC_BIT];

  // external clamp on all three channels
  assign clamp_active_o = {3{clamp_source_sel ? ext_clamp_act : (clp_state == dimc_pkg::CLP_ON)}};
  assign clamp_midscale_o = input_polarity_clamp_clock_control[dimc_pkg::CLAMP_MID_LSB +: 3];

  always_comb begin
    case (mode_control_two[dimc_pkg::DRIVE_MSB:dimc_pkg::DRIVE_LSB])
      2'b11:   drive_strength_o = dimc_pkg::DRV_HIGH;
      2'b10:   drive_strength_o = dimc_pkg::DRV_MED;
      default: drive_strength_o = dimc_pkg::DRV_LOW;
    endcase
  end

endmodule : dimc_mode_ctrl

/* dv/dimc_mode_ctrl_monitor.sv */
// port assertions for the mode-control block
`timescale 1ns/1ps
module dimc_mode_ctrl_monitor (
  input wire logic                  clk_i,
  input wire logic                  sys_rst_i,
  input wire logic [7:0]            reg_addr_i,
  input wire logic [7:0]            reg_wdata_i,
  input wire logic                  reg_wr_i,
  input wire logic [7:0]            reg_rdata_o,
  input wire logic                  digital_if_i,
  input wire logic                  vsync_in_i,
  input wire logic                  green_embedded_sync_i,
  input wire logic                  pll_holdover_input_i,
  input wire logic                  ext_clamp_pin_i,
  input wire logic                  pix_valid_i,
  input wire logic [23:0]           pix_data_i,
  input wire logic [23:0]           port_a_data_o,
  input wire logic [23:0]           port_b_data_o,
  input wire logic                  port_a_oe_o,
  input wire logic [1:0]            data_clk_o,
  input wire logic                  data_clk_oe_o,
  input wire logic                  vsync_o,
  input wire logic                  green_embedded_sync_o,
  input wire logic                  hsync_lead_o,
  input wire logic                  pll_holdover_o,
  input wire logic                  pll_ref_edge_o,
  input wire logic                  pixel_clock_source_sel_o,
  input wire logic [2:0]            clamp_active_o,
  input wire dimc_pkg::dimc_drive_t drive_strength_o
);
  //----------------------------------------
  // register mirrors and checks
  //----------------------------------------
  logic [7:0] m1;
  logic [7:0] m2;
  logic       dual;
  logic       a_first;
  logic       w0e;
  logic       w0f;
  logic       w10;
  assign w0e     = reg_wr_i && reg_addr_i == dimc_pkg::ADDR_MODE_ONE;
  assign w0f     = reg_wr_i && reg_addr_i == dimc_pkg::ADDR_POL_CLAMP;
  assign w10     = reg_wr_i && reg_addr_i == dimc_pkg::ADDR_MODE_TWO;
  assign dual    = digital_if_i ? m2[6] : m1[7];
  assign a_first = !dual || m1[5];
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      m1 <= 8'hF8;
      m2 <= 8'h30;
    end else if (w0e) begin
      m1 <= reg_wdata_i;
    end else if (w10) begin
      m2 <= reg_wdata_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_first;
    hsync_lead_o && pix_valid_i;
  endsequence
  sequence s_next;
    s_first ##1 (pix_valid_i && !hsync_lead_o);
  endsequence
  chk_rdata_unmap: assert property (!(reg_addr_i inside {8'h0E, 8'h0F, 8'h10}) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_vsync_pass: assert property (w0e |=> vsync_o == (vsync_in_i ^ !$past(reg_wdata_i[3])))
    else $error("vsync output sense wrong");
  chk_sog_polarity: assert property (w0e |=> green_embedded_sync_o == (green_embedded_sync_i ^ $past(reg_wdata_i[4])))
    else $error("sog output sense wrong");
  chk_holdover_sense: assert property (w0f |=> pll_holdover_o == (pll_holdover_input_i == $past(reg_wdata_i[6])))
    else $error("holdover sense wrong");
  chk_ext_clamp: assert property (w0f && reg_wdata_i[5] |=> clamp_active_o == {3{ext_clamp_pin_i ^ $past(reg_wdata_i[4])}})
    else $error("external clamp sense wrong");
  chk_drive_code: assert property (w10 |=> drive_strength_o == (!$past(reg_wdata_i[5]) ? dimc_pkg::DRV_LOW :
    ($past(reg_wdata_i[4]) ? dimc_pkg::DRV_HIGH : dimc_pkg::DRV_MED)))
    else $error("drive code wrong");
  chk_tristate_oe: assert property (w10 |=> port_a_oe_o == !$past(reg_wdata_i[3]) && data_clk_oe_o == port_a_oe_o)
    else $error("output enable wrong");
  chk_ref_edge: assert property (pll_ref_edge_o == (hsync_lead_o && !pll_holdover_o && !pixel_clock_source_sel_o))
    else $error("reference edge not gated");
  chk_first_port: assert property (s_first |=> ($past(a_first) ? port_a_data_o : port_b_data_o) == $past(pix_data_i))
    else $error("first sample on wrong port");
  chk_second_port: assert property (s_next |=> ($past(dual && a_first) ? port_b_data_o : port_a_data_o) == $past(pix_data_i))
    else $error("second sample on wrong port");
  chk_dclk_valid: assert property (!digital_if_i && pix_valid_i |=> data_clk_o == 2'h3)
    else $error("analog data clock missing");
endmodule : dimc_mode_ctrl_monitor

/* dv/dimc_pix_sink.sv */
// display controller model capturing the port a stream
`timescale 1ns/1ps
module dimc_pix_sink (
  input  wire logic        clk_i,
  input  wire logic [1:0]  data_clk_i,
  input  wire logic        data_clk_oe_i,
  input  wire logic [23:0] port_a_i,
  output logic      [23:0] last_a_o
);
  //----------------------------------------
  // capture
  //----------------------------------------
  // floated outputs ignored
  always @(posedge clk_i) begin
    if (data_clk_oe_i && data_clk_i[0]) begin
      last_a_o <= port_a_i;
    end
  end
endmodule : dimc_pix_sink

/* dv/dimc_mode_ctrl_tb_top.sv */
// self-checking bench for the mode-control block
`timescale 1ns/1ps
module dimc_mode_ctrl_tb_top;
  logic        clk_i = 1'h0, sys_rst_i = 1'h1, reg_wr_i = 1'h0, dig_i = 1'h0, vld_i = 1'h0;
  logic        hs_i = 1'h0, vs_i = 1'h0, sog_i = 1'h0, hold_i = 1'h0, clp_i = 1'h0;
  logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, rdata;
  logic [23:0] pix_i = 24'h000000, pa, pb, sink_a;
  logic        a_oe, b_oe, dclk_oe, hs_o, sog_o, vs_o, lead, hold_o, ref_o, ck_sel;
  logic [1:0]  dclk, drv;
  logic [2:0]  clamp, mid;
  int          n_mismatch = 0, checks_done = 0, n_clamp, clp_first, cycles = 0;

  dimc_mode_ctrl dimc_mode_ctrl_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr_i), .reg_wdata_i(wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rdata_o(rdata), .digital_if_i(dig_i), .hsync_in_i(hs_i), .vsync_in_i(vs_i),
    .green_embedded_sync_i(sog_i), .pll_holdover_input_i(hold_i), .ext_clamp_pin_i(clp_i),
    .clamp_start_offset_i(8'h02), .clamp_length_i(8'h03), .pix_valid_i(vld_i), .pix_data_i(pix_i),
    .port_a_data_o(pa), .port_a_oe_o(a_oe), .port_b_data_o(pb), .port_b_oe_o(b_oe), .data_clk_o(dclk),
    .data_clk_oe_o(dclk_oe), .hsync_o(hs_o), .green_embedded_sync_o(sog_o), .vsync_o(vs_o),
    .hsync_lead_o(lead), .pll_holdover_o(hold_o), .pll_ref_edge_o(ref_o), .pixel_clock_source_sel_o(ck_sel),
    .clamp_active_o(clamp), .clamp_midscale_o(mid), .drive_strength_o(drv));
  dimc_pix_sink dimc_pix_sink_inst (.clk_i(clk_i), .data_clk_i(dclk), .data_clk_oe_i(dclk_oe), .port_a_i(pa),
    .last_a_o(sink_a));

  //----------------------------------------
  // tasks
  //----------------------------------------
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i); #1;
    addr_i = a;
    wdata_i = d;
    reg_wr_i = 1'h1;
    @(posedge clk_i); #1;
    reg_wr_i = 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i); #1;
    addr_i = a;
    @(posedge clk_i); #1;
    chk("read data", e, rdata);
  endtask : rd
  task automatic burst(input int n);
    @(posedge clk_i); #1;
    hs_i = 1'h0;
    vld_i = 1'h0;
    n_clamp = 0;
    clp_first = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i); #1;
      hs_i = 1'h1;
      vld_i = 1'h1;
      pix_i = 24'hA00000 + 24'(i);
      // skip the lead edge cycle: a cut earlier line may still hold the clamp on
      if (i > 0 && clamp[0] && n_clamp == 0) clp_first = i;
      if (i > 0) n_clamp += clamp[0];
    end
    @(posedge clk_i); #1;
    vld_i = 1'h0;
    @(posedge clk_i); #1;
  endtask : burst
  task automatic steer(input logic [7:0] r1, input logic [7:0] r2, input logic dg, input logic [23:0] ea,
                       input logic [23:0] eb, input logic du);
    wr(8'h0E, r1);
    wr(8'h10, r2);
    dig_i = dg;
    burst(3);
    chk("port a", ea, pa);
    chk("sink a", ea, sink_a);
    chk("port b enable", du, b_oe);
    if (du) chk("port b", eb, pb);
  endtask : steer

  //----------------------------------------
  // tests
  //----------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    #1 sys_rst_i = 1'h0;
    rd(8'h0E, 8'hF8);
    rd(8'h0F, 8'hD0);
    rd(8'h10, 8'h30);
    wr(8'h11, 8'hFF);
    rd(8'h11, 8'h00);
    wr(8'h0E, 8'h07);
    rd(8'h0E, 8'h00);
    wr(8'h0F, 8'hA5);
    rd(8'h0F, 8'hA5);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'hF8);
    chk("outputs floated", 24'h0, {a_oe, dclk_oe});
    for (int d = 0; d < 4; d++) begin
      wr(8'h10, 8'(d << 4));
      chk("drive", 24'(d < 2 ? 0 : d - 1), drv);
      chk("outputs driven", 24'h3, {a_oe, dclk_oe});
    end
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      wr(8'h0E, 8'hE0 | {3'h0, i[1:0], 3'h0});
      hs_i = i[2];
      sog_i = i[2];
      vs_i = i[3];
      #1;
      chk("hsync out", i[2] ^ i[1], hs_o);
      chk("sog out", i[2] ^ i[1], sog_o);
      chk("vsync out", i[3] ^ !i[0], vs_o);
    end
    $display("test sync polarity done");
    for (int i = 0; i < 8; i++) begin
      hold_i = i[2];
      clp_i = i[2];
      wr(8'h0F, {1'h1, i[0], 1'h1, i[1], i[2], i[2:0]});
      chk("holdover", i[2] == i[0], hold_o);
      chk("ext clamp", {3{i[2] ^ i[1]}}, clamp);
      chk("clock source", i[2], ck_sel);
      chk("midscale", i[2:0], mid);
    end
    wr(8'h0F, 8'h50);
    hold_i = 1'h0;
    vld_i = 1'h1;
    hs_i = 1'h1;
    @(posedge clk_i); #1;
    hs_i = 1'h0;
    #1;
    chk("lead on fall", 24'h3, {lead, ref_o});
    @(posedge clk_i); #1;
    hs_i = 1'h1;
    #1;
    chk("lead on rise", 24'h0, {lead, ref_o});
    @(posedge clk_i); #1;
    hold_i = 1'h1;
    hs_i = 1'h0;
    #1;
    chk("lead in holdover", 24'h2, {lead, ref_o});
    vld_i = 1'h0;
    hold_i = 1'h0;
    wr(8'h0F, 8'hD0);
    $display("test inputs done");
    steer(8'hF8, 8'h30, 1'h0, 24'hA00002, 24'hA00001, 1'h1);
    steer(8'hD8, 8'h30, 1'h0, 24'hA00001, 24'hA00002, 1'h1);
    steer(8'h58, 8'h30, 1'h0, 24'hA00002, 24'h0, 1'h0);
    steer(8'hF8, 8'h30, 1'h1, 24'hA00002, 24'h0, 1'h0);
    steer(8'hF8, 8'h70, 1'h1, 24'hA00002, 24'hA00001, 1'h1);
    wr(8'h10, 8'hF0);
    @(posedge clk_i); #1;
    chk("data clock flipped", 24'h3, dclk);
    dig_i = 1'h0;
    @(posedge clk_i); #1;
    chk("data clock analog", 24'h0, dclk);
    wr(8'h10, 8'h30);
    $display("test steering done");
    burst(12);
    chk("clamp length", 24'h3, 24'(n_clamp));
    chk("clamp start", 24'h3, 24'(clp_first));
    $display("test clamp done");
    report_and_stop();
  end
endmodule : dimc_mode_ctrl_tb_top

bind dimc_mode_ctrl dimc_mode_ctrl_monitor dimc_mode_ctrl_monitor_inst (.*);
